// *** common/ssf_pkg.sv ***
// constants, field positions and carriers for the sync status and output format registers
// assumes a byte-wide register port decoded by the serial control interface
package ssf_pkg;
   localparam logic [7:0] ADDR_STATUS = 8'h14;
   localparam logic [7:0] ADDR_FORMAT = 8'h15;
   localparam logic [7:0] ADDR_LOOP = 8'h16;
   localparam logic [7:0] ADDR_OETEST = 8'h17;
   localparam logic [7:0] ADDR_POLCSC = 8'h18;
   localparam logic [7:0] ADDR_MUX = 8'h19;
   localparam logic [7:0] RST_FORMAT = 8'h04;
   localparam logic [7:0] RST_LOOP = 8'h11;
   localparam logic [7:0] RST_OETEST = 8'h03;
   localparam logic [7:0] RST_POLCSC = 8'h00;
   localparam logic [7:0] RST_MUX = 8'h00;
   localparam logic [7:0] MASK_FORMAT = 8'h6F;
   localparam logic [7:0] MASK_LOOP = 8'h13;
   localparam logic [7:0] MASK_OETEST = 8'h73;
   localparam logic [7:0] MASK_POLCSC = 8'h37;
   // output formatter fields
   localparam int F_SYNC_EN = 0, F_DECIM = 1, F_CHROMA_ORDER = 2, F_CLAMP_REF = 3, F_RANGE = 5;
   // loop and output enable fields
   localparam int L_STARTUP = 0, L_POWERDOWN = 1;
   localparam int O_OUT_EN_N = 0, O_GREEN_SYNC_OUT_ENABLE_N_N = 1, O_TEST_SEL = 4;
   // polarity and converter fields
   localparam int P_CLK_INV = 0, P_SOG_INV = 1, P_FIELD_INV = 2, P_COLOUR_CONVERT_ENABLE = 4, P_BLANK_EN = 5;
   // status bit positions: channel index 0 hsync, 1 vsync, 2 sog, 3 coast
   localparam int S_COAST_POL = 0, S_SOG_ACT = 1, S_VS_POL = 2, S_AVS = 3;
   localparam int S_VS_ACT = 4, S_HS_POL = 5, S_AHS = 6, S_HS_ACT = 7;
   localparam logic [1:0] RANGE_FULL = 2'b00, RANGE_EXT = 2'b01, RANGE_STUDIO = 2'b10;
   localparam logic [9:0] CODE_MIN = 10'h000, CODE_MAX = 10'h3FF;
   localparam logic [9:0] EXT_MIN = 10'h004, EXT_MAX = 10'h3FB;
   localparam logic [9:0] STU_MIN = 10'h040, Y_STU_MAX = 10'h3AC, C_STU_MAX = 10'h3C0;
   localparam logic [9:0] Y_BLANK = 10'h040, C_BLANK = 10'h200;
   localparam logic [2:0] T_FIELD = 3'b000, T_DE = 3'b001, T_REFCLK = 3'b100;
   localparam logic [2:0] T_COAST = 3'b101, T_CLAMP = 3'b110;
   localparam int NUM_DET = 4;
   localparam int SYS_CLOCK_HZ = 10000000;
   localparam int REF_CLOCK_HZ = 6500000;
   // nearest divide that does not run faster than the reference
   localparam int REF_DIV = (SYS_CLOCK_HZ + REF_CLOCK_HZ - 1) / REF_CLOCK_HZ;
   typedef struct packed {
      logic [9:0] y;
      logic [9:0] cb;
      logic [9:0] cr;
   } ssf_pix_t;
   typedef struct packed {
      logic [2:0] sog;
      logic [2:0] red;
      logic [3:0] green;
      logic [2:0] blue;
   } ssf_mux_t;
endpackage

// *** hw/ssf_regs.sv ***
// sync detect status, output formatter and misc control register group with its datapath
// assumes the serial control interface decodes subaddress, data and one-cycle strobes
// Function
// - report hsync, vsync, sog activity flags
// - report active hsync source, input or sog
// - report active vsync source, input or separator
// - detect hsync, vsync, coast input polarity
// - clamp output codes to selected range
// - clamp reference from trailing or leading edge
// - chroma order applies only in 4:2:2
// - decimation selects 4:4:4 or 4:2:2 output
// - embedded sync only in valid modes, both outputs
// - discrete syncs always driven, never hi-z
// - loop power down bit
// - loop start-up enable bit
// - test output multiplexer select
// - sog output enable, active low
// - main output enable, active low
// - data enable follows active video
// - blank enable forces standard blank level, only while embedded sync is valid
// - colour converter applied or bypassed
// - field polarity invert, also data enable
// - sog output invert, data clock edge
// - analog input selects, green has fourth
// - activity detection on internal reference rate
`timescale 1ns/1ns
module ssf_regs #(
   parameter int ACT_WIN = 65535
) (
   input wire logic clock,
   input wire logic rst,
   input wire logic [7:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic reg_write,
   input wire logic reg_read,
   output logic [7:0] reg_rdata,
   input wire logic hsync_in,
   input wire logic vsync_in,
   input wire logic green_sync_in,
   input wire logic coast_in,
   input wire logic sep_vsync_in,
   input wire logic hsync_override,
   input wire logic hsync_select,
   input wire logic vsync_override,
   input wire logic vsync_select,
   input wire logic field_in,
   input wire logic active_video_in,
   input wire logic clamp_pulse_in,
   input wire ssf_pkg::ssf_pix_t pix_in,
   output ssf_pkg::ssf_pix_t pix_out,
   output logic pix_oe,
   output logic output_data_clock,
   output logic hsync_output,
   output logic vsync_output,
   output logic field_output,
   output logic green_sync_output,
   output logic green_sync_oe,
   output logic test_output,
   output logic test_oe,
   output logic clamp_ref_pulse,
   output logic hloop_powerdown,
   output logic hloop_startup_enable,
   output ssf_pkg::ssf_mux_t input_select
);
   // ************************************************************
   // state
   // ************************************************************
   typedef struct packed {
      logic prev;
      logic seen;
      logic [15:0] hi;
      logic [15:0] lo;
   } ssf_det_t;
   typedef struct packed {
      logic [7:0] fmt;
      logic [7:0] loop;
      logic [7:0] oetest;
      logic [7:0] polcsc;
      logic [7:0] mux;
      logic [7:0] rdata;
      logic [3:0] act;
      logic [3:0] pol;
      logic [3:0] ref_cnt;
      logic ref_tick;
      logic ref_clk;
      logic [15:0] win;
      ssf_det_t [ssf_pkg::NUM_DET-1:0] det;
      logic hs_prev;
      logic clamp_pulse;
      logic dclk;
      logic phase;
      logic [1:0] trs;
      ssf_pkg::ssf_pix_t pix;
   } ssf_state_t;

   ssf_state_t st;
   ssf_state_t next_st;

   function automatic logic [9:0] ssf_clip(input logic [11:0] v, input logic [9:0] lo, input logic [9:0] hi);
      if (v[11]) begin
         ssf_clip = lo;
      end else if (v[10:0] < {1'b0, lo}) begin
         ssf_clip = lo;
      end else if (v[10:0] > {1'b0, hi}) begin
         ssf_clip = hi;
      end else begin
         ssf_clip = v[9:0];
      end
   endfunction

   // ************************************************************
   // combinational next state
   // ************************************************************
   logic [3:0] raw;
   logic active_hsync_source;
   logic active_vsync_source;
   logic hs_lvl;
   logic hs_lvl_pol;
   logic [1:0] range_sel;
   logic decim;
   logic embed_ok;
   logic launch;
   logic [9:0] ylo, yhi, clo, chi;
   logic [11:0] cy, ccb, ccr;
   ssf_pkg::ssf_pix_t conv;
   logic [9:0] c_word;
   logic [7:0] status;

   always_comb begin
      next_st = st;
      c_word = 10'h000;
      raw = {coast_in, green_sync_in, vsync_in, hsync_in};
      // automatic choice prefers the discrete input when it is active
      active_hsync_source = hsync_override ? hsync_select : ~st.act[0];
      active_vsync_source = vsync_override ? vsync_select : ~st.act[1];
      status = 8'h00;
      status[ssf_pkg::S_HS_ACT] = st.act[0];
      status[ssf_pkg::S_VS_ACT] = st.act[1];
      status[ssf_pkg::S_SOG_ACT] = st.act[2];
      status[ssf_pkg::S_AHS] = active_hsync_source;
      status[ssf_pkg::S_AVS] = active_vsync_source;
      status[ssf_pkg::S_HS_POL] = st.pol[0];
      status[ssf_pkg::S_VS_POL] = st.pol[1];
      status[ssf_pkg::S_COAST_POL] = st.pol[3];

      // register port; status offset accepts no write
      if (reg_write) begin
         case (reg_addr)
            ssf_pkg::ADDR_FORMAT: next_st.fmt = reg_wdata & ssf_pkg::MASK_FORMAT;
            ssf_pkg::ADDR_LOOP: next_st.loop = reg_wdata & ssf_pkg::MASK_LOOP;
            ssf_pkg::ADDR_OETEST: next_st.oetest = reg_wdata & ssf_pkg::MASK_OETEST;
            ssf_pkg::ADDR_POLCSC: next_st.polcsc = reg_wdata & ssf_pkg::MASK_POLCSC;
            ssf_pkg::ADDR_MUX: next_st.mux = reg_wdata;
            default: next_st.fmt = st.fmt;
         endcase
      end
      if (reg_read) begin
         case (reg_addr)
            ssf_pkg::ADDR_STATUS: next_st.rdata = status;
            ssf_pkg::ADDR_FORMAT: next_st.rdata = st.fmt;
            ssf_pkg::ADDR_LOOP: next_st.rdata = st.loop;
            ssf_pkg::ADDR_OETEST: next_st.rdata = st.oetest;
            ssf_pkg::ADDR_POLCSC: next_st.rdata = st.polcsc;
            ssf_pkg::ADDR_MUX: next_st.rdata = st.mux;
            default: next_st.rdata = 8'h00;
         endcase
      end

      // internal reference rate enable; approximate, like the real one
      next_st.ref_tick = 1'b0;
      if (st.ref_cnt == 4'(ssf_pkg::REF_DIV - 1)) begin
         next_st.ref_cnt = 4'h0;
         next_st.ref_tick = 1'b1;
         next_st.ref_clk = ~st.ref_clk;
      end else begin
         next_st.ref_cnt = st.ref_cnt + 4'h1;
      end

      // activity and polarity: a short high time means an active-high pulse
      if (st.ref_tick) begin
         for (int i = 0; i < ssf_pkg::NUM_DET; i++) begin
            next_st.det[i].prev = raw[i];
            if (raw[i] != st.det[i].prev) begin
               next_st.det[i].seen = 1'b1;
            end
            if (raw[i] && st.det[i].hi != 16'hFFFF) begin
               next_st.det[i].hi = st.det[i].hi + 16'h0001;
            end
            if (!raw[i] && st.det[i].lo != 16'hFFFF) begin
               next_st.det[i].lo = st.det[i].lo + 16'h0001;
            end
         end
         if (st.win == 16'(ACT_WIN - 1)) begin
            next_st.win = 16'h0000;
            for (int i = 0; i < ssf_pkg::NUM_DET; i++) begin
               next_st.act[i] = st.det[i].seen;
               next_st.pol[i] = st.det[i].hi < st.det[i].lo;
               // an edge on the closing tick opens the next window as seen
               next_st.det[i].seen = raw[i] != st.det[i].prev;
               next_st.det[i].hi = 16'h0000;
               next_st.det[i].lo = 16'h0000;
            end
         end else begin
            next_st.win = st.win + 16'h0001;
         end
      end

      // active hsync brought to active-high; sog sync is taken as active low
      hs_lvl_pol = active_hsync_source ? 1'b0 : st.pol[0];
      hs_lvl = (active_hsync_source ? green_sync_in : hsync_in) ~^ hs_lvl_pol;
      next_st.hs_prev = hs_lvl;
      next_st.clamp_pulse = 1'b0;
      if (st.fmt[ssf_pkg::F_CLAMP_REF]) begin
         next_st.clamp_pulse = hs_lvl & ~st.hs_prev;
      end else begin
         next_st.clamp_pulse = ~hs_lvl & st.hs_prev;
      end

      // output data clock at half rate; launch edge chosen by polarity
      next_st.dclk = ~st.dclk;
      launch = (st.dclk == st.polcsc[ssf_pkg::P_CLK_INV]);

      range_sel = st.fmt[ssf_pkg::F_RANGE +: 2];
      decim = st.fmt[ssf_pkg::F_DECIM];
      // embedded sync refused in full range or 4:4:4
      embed_ok = st.fmt[ssf_pkg::F_SYNC_EN] && range_sel != ssf_pkg::RANGE_FULL && decim;
      case (range_sel)
         ssf_pkg::RANGE_EXT: begin
            ylo = ssf_pkg::EXT_MIN;
            yhi = ssf_pkg::EXT_MAX;
            clo = ssf_pkg::EXT_MIN;
            chi = ssf_pkg::EXT_MAX;
         end
         ssf_pkg::RANGE_STUDIO: begin
            ylo = ssf_pkg::STU_MIN;
            yhi = ssf_pkg::Y_STU_MAX;
            clo = ssf_pkg::STU_MIN;
            chi = ssf_pkg::C_STU_MAX;
         end
         default: begin
            ylo = ssf_pkg::CODE_MIN;
            yhi = ssf_pkg::CODE_MAX;
            clo = ssf_pkg::CODE_MIN;
            chi = ssf_pkg::CODE_MAX;
         end
      endcase

      // fixed shift converter: y from g,b,r; chroma as scaled differences
      cy = (12'(pix_in.y) * 12'h002 + 12'(pix_in.cb) + 12'(pix_in.cr)) >> 2;
      ccb = ((12'(pix_in.cb) + 12'h400 - cy) >> 1);
      ccr = ((12'(pix_in.cr) + 12'h400 - cy) >> 1);
      if (st.polcsc[ssf_pkg::P_COLOUR_CONVERT_ENABLE]) begin
         conv.y = ssf_clip(cy, ylo, yhi);
         conv.cb = ssf_clip(ccb, clo, chi);
         conv.cr = ssf_clip(ccr, clo, chi);
      end else begin
         conv.y = ssf_clip(12'(pix_in.y), ylo, yhi);
         conv.cb = ssf_clip(12'(pix_in.cb), clo, chi);
         conv.cr = ssf_clip(12'(pix_in.cr), clo, chi);
      end
      // standard blank level only while embedded syncs are in use
      if (embed_ok && st.polcsc[ssf_pkg::P_BLANK_EN] && !active_video_in) begin
         conv.y = ssf_pkg::Y_BLANK;
         conv.cb = ssf_pkg::C_BLANK;
         conv.cr = ssf_pkg::C_BLANK;
      end

      if (launch) begin
         next_st.phase = ~st.phase;
         if (decim) begin
            // chroma shares the blue bus; order swaps only in this mode
            if (st.phase ^ st.fmt[ssf_pkg::F_CHROMA_ORDER]) begin
               c_word = conv.cr;
            end else begin
               c_word = conv.cb;
            end
            next_st.pix.y = conv.y;
            next_st.pix.cb = c_word;
            next_st.pix.cr = 10'h000;
         end else begin
            next_st.pix = conv;
         end
         // timing reference words on both luma and chroma after sync edge
         if (embed_ok && (st.trs != 2'b00 || (hs_lvl && !st.hs_prev))) begin
            next_st.trs = st.trs + 2'b01;
            case (st.trs)
               2'b00: c_word = ssf_pkg::CODE_MAX;
               2'b11: c_word = {1'b1, field_in, ~active_video_in, 1'b1, 6'h00};
               default: c_word = ssf_pkg::CODE_MIN;
            endcase
            next_st.pix.y = c_word;
            next_st.pix.cb = c_word;
         end
      end else begin
         c_word = 10'h000;
      end
   end

   // ************************************************************
   // registers
   // ************************************************************
   always_ff @(posedge clock) begin
      if (rst) begin
         st <= '0;
         st.fmt <= ssf_pkg::RST_FORMAT;
         st.loop <= ssf_pkg::RST_LOOP;
         st.oetest <= ssf_pkg::RST_OETEST;
         st.polcsc <= ssf_pkg::RST_POLCSC;
         st.mux <= ssf_pkg::RST_MUX;
      end else begin
         st <= next_st;
      end
   end

   // ************************************************************
   // outputs
   // ************************************************************
   function automatic logic [3:0] ssf_onehot(input logic [1:0] code, input logic four);
      ssf_onehot = 4'h0;
      if (code != 2'b11 || four) begin
         ssf_onehot[code] = 1'b1;
      end
   endfunction

   logic [3:0] sel_sog, sel_red, sel_blue;
   logic field_pol;
   logic [2:0] tsel;

   assign reg_rdata = st.rdata;
   assign pix_out = st.pix;
   assign output_data_clock = st.dclk;
   assign pix_oe = ~st.oetest[ssf_pkg::O_OUT_EN_N];
   // discrete syncs always drive, not gated by the main enable or any other
   assign hsync_output = hs_lvl;
   assign vsync_output = active_vsync_source ? sep_vsync_in : vsync_in;
   assign field_pol = st.polcsc[ssf_pkg::P_FIELD_INV];
   assign field_output = field_in ^ field_pol;
   assign green_sync_output = green_sync_in ^ st.polcsc[ssf_pkg::P_SOG_INV];
   assign green_sync_oe = ~st.oetest[ssf_pkg::O_GREEN_SYNC_OUT_ENABLE_N_N];
   assign clamp_ref_pulse = st.clamp_pulse;
   assign hloop_powerdown = st.loop[ssf_pkg::L_POWERDOWN];
   assign hloop_startup_enable = st.loop[ssf_pkg::L_STARTUP];
   assign tsel = st.oetest[ssf_pkg::O_TEST_SEL +: 3];

   always_comb begin
      test_oe = 1'b1;
      case (tsel)
         ssf_pkg::T_FIELD: test_output = field_in ^ field_pol;
         ssf_pkg::T_DE: test_output = active_video_in ^ field_pol;
         ssf_pkg::T_REFCLK: test_output = st.ref_clk;
         ssf_pkg::T_COAST: test_output = coast_in;
         ssf_pkg::T_CLAMP: test_output = clamp_pulse_in;
         default: begin
            // reserved codes float like the high-impedance code
            test_output = 1'b0;
            test_oe = 1'b0;
         end
      endcase
   end

   // reserved code leaves the channel unconnected rather than guessing
   assign sel_sog = ssf_onehot(st.mux[7:6], 1'b0);
   assign sel_red = ssf_onehot(st.mux[5:4], 1'b0);
   assign sel_blue = ssf_onehot(st.mux[1:0], 1'b0);
   assign input_select.sog = sel_sog[2:0];
   assign input_select.red = sel_red[2:0];
   assign input_select.green = ssf_onehot(st.mux[3:2], 1'b1);
   assign input_select.blue = sel_blue[2:0];
endmodule // ssf_regs

// *** testbench/ssf_host_model.sv ***
// host side of the byte register port
// assumes strobes are taken on the rising clock edge
`timescale 1ns/1ns
module ssf_host_model (
   input wire logic clock,
   output logic [7:0] reg_addr,
   output logic [7:0] reg_wdata,
   output logic reg_write,
   output logic reg_read,
   input wire logic [7:0] reg_rdata
);
   // ********************
   // bus cycles
   // ********************
   initial begin
      reg_addr = 8'h00;
      reg_wdata = 8'h00;
      reg_write = 1'b0;
      reg_read = 1'b0;
   end
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clock);
      reg_wdata <= (a == ssf_pkg::ADDR_FORMAT) ? (d & 8'h6F) : d;
      reg_addr <= a;
      reg_write <= 1'b1;
      @(posedge clock);
      reg_write <= 1'b0;
      // released lines flip so stale data never looks valid
      reg_addr <= ~a;
      reg_wdata <= ~d;
   endtask
   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      @(posedge clock);
      reg_addr <= a;
      reg_read <= 1'b1;
      @(posedge clock);
      reg_read <= 1'b0;
      reg_addr <= ~a;
      #1;
      d = reg_rdata;
   endtask
endmodule // ssf_host_model

// *** testbench/ssf_regs_checker.sv ***
// concurrent checks on the register group outputs
// assumes a bind onto ssf_regs and a single clock domain
`timescale 1ns/1ns
module ssf_regs_checker (
   input wire logic clock,
   input wire logic rst,
   input wire logic [7:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic reg_write,
   input wire logic field_in,
   input wire logic active_video_in,
   input wire logic green_sync_in,
   input wire logic pix_oe,
   input wire logic output_data_clock,
   input wire logic field_output,
   input wire logic green_sync_output,
   input wire logic green_sync_oe,
   input wire logic test_output,
   input wire logic test_oe,
   input wire logic clamp_ref_pulse,
   input wire logic hloop_powerdown,
   input wire logic hloop_startup_enable,
   input wire ssf_pkg::ssf_mux_t input_select
);
   // ********************
   // shadows and assertions
   // ********************
   logic [7:0] sh17;
   logic [7:0] sh18;
   logic [7:0] sh19;
   wire pd_w = reg_wdata[1];
   wire st_w = reg_wdata[0];
   wire [2:0] tsel = sh17[6:4];
   wire [2:0] red_x = (sh19[5:4] == 2'b11) ? 3'h0 : 3'h1 << sh19[5:4];
   // raw shadows: only bits with a defined meaning are ever compared
   always_ff @(posedge clock) begin
      if (rst) begin
         sh17 <= 8'h03;
         sh18 <= 8'h00;
         sh19 <= 8'h00;
      end else if (reg_write) begin
         if (reg_addr == ssf_pkg::ADDR_OETEST) sh17 <= reg_wdata;
         if (reg_addr == ssf_pkg::ADDR_POLCSC) sh18 <= reg_wdata;
         if (reg_addr == ssf_pkg::ADDR_MUX) sh19 <= reg_wdata;
      end
   end
   default clocking @(posedge clock); endclocking
   default disable iff (rst);
   sequence wr_s(logic [7:0] a);
      reg_write && reg_addr == a;
   endsequence
   main_oe_a: assert property (pix_oe == !sh17[0]) else $error("main enable wrong");
   sog_oe_a: assert property (green_sync_oe == !sh17[1]) else $error("sog enable wrong");
   test_oe_a: assert property (test_oe == !(tsel inside {3'b010, 3'b011, 3'b111}))
      else $error("test enable wrong");
   field_pol_a: assert property (field_output == (field_in ^ sh18[2])) else $error("field wrong");
   de_tst_a: assert property (tsel == ssf_pkg::T_DE |-> test_output == (active_video_in ^ sh18[2]))
      else $error("data enable wrong");
   sog_inv_a: assert property (green_sync_output == (green_sync_in ^ sh18[1])) else $error("sog wrong");
   loop_bits_a: assert property (wr_s(ssf_pkg::ADDR_LOOP) |=> hloop_powerdown == $past(pd_w)
      && hloop_startup_enable == $past(st_w)) else $error("loop bits wrong");
   mux_sel_a: assert property (input_select.green == 4'h1 << sh19[3:2] && input_select.red == red_x)
      else $error("input select wrong");
   clamp_pulse_a: assert property (clamp_ref_pulse |=> !clamp_ref_pulse) else $error("clamp pulse long");
   dclk_tog_a: assert property (!$past(rst) |-> output_data_clock != $past(output_data_clock))
      else $error("data clock stuck");
endmodule // ssf_regs_checker
bind ssf_regs ssf_regs_checker u_chk (.clock(clock), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
   .reg_write(reg_write), .field_in(field_in), .active_video_in(active_video_in), .green_sync_in(green_sync_in),
   .pix_oe(pix_oe), .output_data_clock(output_data_clock), .field_output(field_output),
   .green_sync_output(green_sync_output), .green_sync_oe(green_sync_oe), .test_output(test_output),
   .test_oe(test_oe), .clamp_ref_pulse(clamp_ref_pulse), .hloop_powerdown(hloop_powerdown),
   .hloop_startup_enable(hloop_startup_enable), .input_select(input_select));

// *** testbench/tb_top.sv ***
// register sequence tests for the sync status and output format group
// assumes the host model drives the byte port, activity window shortened
`timescale 1ns/1ns
module tb_top;
   // ********************
   // bench
   // ********************
   logic clock = 1'b0;
   logic rst = 1'b1;
   logic [7:0] reg_addr, reg_wdata, reg_rdata, d;
   logic reg_write, reg_read, pix_oe, output_data_clock, hsync_output, vsync_output, field_output;
   logic green_sync_output, green_sync_oe, test_output, test_oe, clamp_ref_pulse;
   logic hloop_powerdown, hloop_startup_enable;
   logic hsync_in = 1'b0, vsync_in = 1'b0, green_sync_in = 1'b0, coast_in = 1'b0, sep_vsync_in = 1'b0;
   logic field_in = 1'b0, active_video_in = 1'b0, pol = 1'b0, clamp_in = 1'b0;
   logic [9:0] c_prev;
   logic [3:0] m = 4'h0;
   logic [2:0] ph = 3'h0, o3;
   ssf_pkg::ssf_pix_t pix_in = '0, pix_out;
   ssf_pkg::ssf_mux_t input_select;
   int errors = 0, compares = 0;
   logic [7:0] rv [5] = '{ssf_pkg::RST_FORMAT, 8'h11, 8'h03, 8'h00, 8'h00};
   logic [7:0] mk [5] = '{8'h6F, 8'h13, 8'h73, 8'h37, 8'hFF};
   logic [9:0] ylo [3] = '{10'h000, 10'h004, 10'h040}, yhi [3] = '{10'h3FF, 10'h3FB, 10'h3AC};
   logic [9:0] chi [3] = '{10'h3FF, 10'h3FB, 10'h3C0};
   logic [7:0] sm [3] = '{8'h0F, 8'h0F, 8'h02}, sx [3] = '{8'hFF, 8'hFF, 8'hDA}, se [3] = '{8'hB7, 8'h92, 8'h4A};
   always #50 clock = ~clock;
   // sync lines high two clocks in eight, so every other-clock tick sees them
   always @(posedge clock) begin
      ph <= ph + 3'h1;
      {hsync_in, vsync_in, green_sync_in, coast_in} <= {4{(ph < 3'h2) ^ pol}} & m;
      sep_vsync_in <= ph[2];
      clamp_in <= ph[0];
   end
   ssf_host_model u_host (.clock(clock), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_write(reg_write),
      .reg_read(reg_read), .reg_rdata(reg_rdata));
   ssf_regs #(.ACT_WIN(8)) u_dut (.clock(clock), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata), .hsync_in(hsync_in),
      .vsync_in(vsync_in), .green_sync_in(green_sync_in), .coast_in(coast_in), .sep_vsync_in(sep_vsync_in),
      .hsync_override(1'b0), .hsync_select(1'b0), .vsync_override(1'b0), .vsync_select(1'b0),
      .field_in(field_in), .active_video_in(active_video_in), .clamp_pulse_in(clamp_in), .pix_in(pix_in),
      .pix_out(pix_out), .pix_oe(pix_oe), .output_data_clock(output_data_clock), .hsync_output(hsync_output),
      .vsync_output(vsync_output), .field_output(field_output), .green_sync_output(green_sync_output),
      .green_sync_oe(green_sync_oe), .test_output(test_output), .test_oe(test_oe),
      .clamp_ref_pulse(clamp_ref_pulse), .hloop_powerdown(hloop_powerdown),
      .hloop_startup_enable(hloop_startup_enable), .input_select(input_select));
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      compares++;
      if (got !== exp) begin
         errors++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic step(input int n);
      repeat (n) @(posedge clock);
      #1;
   endtask
   task close_out;
      $display("compares %0d errors %0d", compares, errors);
      if (errors == 0 && compares > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask
   initial begin
      repeat (20000) @(posedge clock);
      errors++;
      close_out;
   end
   initial begin
      repeat (12) @(posedge clock);
      rst <= 1'b0;
      for (int i = 0; i < 5; i++) begin
         u_host.rd(8'h15 + 8'(i), d);
         chk(d, rv[i]);
         u_host.wr(8'h15 + 8'(i), 8'hFF);
         u_host.rd(8'h15 + 8'(i), d);
         chk(d, mk[i]);
         u_host.wr(8'h15 + 8'(i), rv[i]);
      end
      u_host.wr(8'h1A, 8'h5A);
      u_host.rd(8'h1A, d);
      chk(d, 8'h00);
      $display("test registers done");
      u_host.wr(ssf_pkg::ADDR_LOOP, 8'h02);
      step(1);
      chk({hloop_powerdown, hloop_startup_enable}, 2'b10);
      chk({pix_oe, green_sync_oe}, 2'b00);
      for (int t = 0; t < 8; t++) begin
         u_host.wr(ssf_pkg::ADDR_OETEST, {1'b0, 3'(t), 4'h0});
         step(1);
         chk({pix_oe, green_sync_oe, test_oe}, {2'b11, !(t inside {2, 3, 7})});
         if (t inside {5, 6}) chk(test_output, (t == 5) ? coast_in : clamp_in);
      end
      for (int k = 0; k < 8; k++) begin
         u_host.wr(ssf_pkg::ADDR_POLCSC, {5'h0, k[1], k[1], 1'b0});
         u_host.wr(ssf_pkg::ADDR_OETEST, {3'h0, k[2], 4'h0});
         @(posedge clock);
         field_in <= k[0];
         active_video_in <= !k[0];
         step(1);
         chk({field_output, green_sync_output}, {k[0] ^ k[1], k[1]});
         chk(test_output, (k[2] ? !k[0] : k[0]) ^ k[1]);
      end
      for (int c = 0; c < 4; c++) begin
         u_host.wr(ssf_pkg::ADDR_MUX, {4{2'(c)}});
         step(1);
         o3 = (c == 3) ? 3'h0 : 3'h1 << c;
         chk(input_select, {o3, o3, 4'h1 << c, o3});
      end
      $display("test controls done");
      for (int r = 0; r < 3; r++) begin
         u_host.wr(ssf_pkg::ADDR_FORMAT, {1'b0, 2'(r), 5'h0});
         for (int h = 0; h < 2; h++) begin
            @(posedge clock);
            pix_in <= {30{h[0]}};
            step(6);
            chk(pix_out, h ? {yhi[r], chi[r], chi[r]} : {ylo[r], ylo[r], ylo[r]});
         end
      end
      // extended range, 4:2:2, no embedded sync: chroma alternates on the blue bus
      u_host.wr(ssf_pkg::ADDR_FORMAT, 8'h22);
      @(posedge clock);
      pix_in <= {10'h100, 10'h080, 10'h300};
      step(6);
      c_prev = pix_out.cb;
      step(2);
      chk({pix_out.y, pix_out.cr}, {10'h100, 10'h000});
      chk(pix_out.cb ^ c_prev, 10'h380);
      $display("test ranges done");
      for (int s = 0; s < 3; s++) begin
         @(posedge clock);
         m <= sm[s][3:0];
         pol <= (s == 1);
         step(40);
         u_host.rd(ssf_pkg::ADDR_STATUS, d);
         chk(d & sx[s], se[s]);
         chk({hsync_output, vsync_output},
            (s == 2) ? {!green_sync_in, sep_vsync_in} : {hsync_in ^ (s == 1), vsync_in});
      end
      u_host.wr(ssf_pkg::ADDR_STATUS, 8'hFF);
      u_host.rd(ssf_pkg::ADDR_STATUS, d);
      chk(d & 8'hDA, 8'h4A);
      $display("test status done");
      close_out;
   end
endmodule // tb_top
